// ==== logic/pfb_datapath.sv ====
// planar frame buffer read/write datapath with indexed control registers
// Overview of operation
// - write mode 0: enabled planes take eight copies of their fill bit
// - write mode 0: other planes take rotated cpu byte
// - write mode 1: each plane rewritten from its read latch
// - write mode 2: cpu data bit n spread over plane n
// - write mode 2: masked-off bit positions come from the latches
// - write mode 3: rotated byte AND bit mask masks the fill colour
// - function field: pass, AND, OR or XOR with latch data
// - rotate count gives right rotation of cpu write data
// - read mode 0 returns the byte of the selected plane
// - odd/even ignores select bit 0; chain four ignores both bits
// - read mode 1 returns per-bit colour match over included planes
// - plane select also picks the latch shown on readback
// - every frame buffer read loads all four latches unaltered
// - chain four: address bits 1:0 steer planes; odd/even: bit 0; else plane mask decides
// - shift mode 01 sends bit pairs, planes 0/2 then 1/3
// - shift mode 1x sends upper then lower nibble, planes 0 to 3
// - reserved register bits read back as zero
// - bit mask keeps latch bits where 0, new data where 1
// - colour ignore bit 1 includes plane in comparison
`default_nettype none
module pfb_datapath #(
	parameter int ADDR_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	// indexed register port
	input wire pfb_pkg::pfb_io_req_t io_req,
	output logic [7:0] io_rdata,
	// controls held in other register groups
	input wire logic [7:0] pixel_write_mask,
	input wire logic [3:0] colour_ignore_mask,
	input wire logic [3:0] plane_write_mask,
	input wire logic chain_four,
	// cpu frame buffer access
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic cpu_busy,
	output logic [7:0] cpu_rdata,
	output logic cpu_rdone,
	output logic [7:0] latch_readback,
	// memory planes
	output pfb_pkg::pfb_mem_req_t mem_req,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	// display serialiser
	input wire logic disp_load,
	input wire logic [31:0] disp_data,
	output logic [3:0] pixel_out,
	output logic pixel_valid
);
	generate
		if (ADDR_W < 2)
		begin : g_bad_addr
			$error("pfb_datapath: ADDR_W must be at least 2");
		end
	endgenerate

	typedef enum logic {
		pfb_idle,
		pfb_rd_wait
	} pfb_state_t;

	logic [7:0] index;
	logic [3:0] fill_value;
	logic [3:0] fill_enable;
	logic [3:0] colour_match;
	logic [4:0] rotate_logic;
	logic [1:0] read_plane;
	logic [6:0] access_mode;
	logic [7:0] latch [pfb_pkg::NUM_PLANES];
	pfb_state_t state;
	logic [1:0] rd_plane_q;
	logic [31:0] next_wdata;
	logic [3:0] next_plane_en;
	logic [1:0] eff_plane;
	logic [7:0] rot_data;
	logic [7:0] cmp_bits;
	logic [1:0] wmode;
	logic [7:0] shift_buf [pfb_pkg::NUM_PLANES];
	logic [2:0] xfer;
	logic shifting;
	logic [3:0] next_pixel;

	assign wmode = access_mode[pfb_pkg::WMODE_LSB +: 2];

	// host register port
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			index <= 8'h00;
			fill_value <= pfb_pkg::RST_NIBBLE;
			fill_enable <= pfb_pkg::RST_NIBBLE;
			colour_match <= pfb_pkg::RST_NIBBLE;
			rotate_logic <= pfb_pkg::RST_ROTATE_LOGIC;
			read_plane <= pfb_pkg::RST_READ_PLANE;
			access_mode <= pfb_pkg::RST_ACCESS_MODE;
		end
		else if (io_req.index_wr)
			index <= io_req.wdata;
		else if (io_req.data_wr)
		begin
			case (index)
				pfb_pkg::IDX_FILL_VALUE: fill_value <= io_req.wdata[3:0];
				pfb_pkg::IDX_FILL_ENABLE: fill_enable <= io_req.wdata[3:0];
				pfb_pkg::IDX_COLOUR_MATCH: colour_match <= io_req.wdata[3:0];
				pfb_pkg::IDX_ROTATE_LOGIC: rotate_logic <= io_req.wdata[4:0];
				pfb_pkg::IDX_READ_PLANE: read_plane <= io_req.wdata[1:0];
				pfb_pkg::IDX_ACCESS_MODE: access_mode <= io_req.wdata[6:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			io_rdata <= 8'h00;
		else if (io_req.data_rd)
		begin
			case (index)
				pfb_pkg::IDX_FILL_VALUE: io_rdata <= {4'h0, fill_value};
				pfb_pkg::IDX_FILL_ENABLE: io_rdata <= {4'h0, fill_enable};
				pfb_pkg::IDX_COLOUR_MATCH: io_rdata <= {4'h0, colour_match};
				pfb_pkg::IDX_ROTATE_LOGIC: io_rdata <= {3'h0, rotate_logic};
				pfb_pkg::IDX_READ_PLANE: io_rdata <= {6'h00, read_plane};
				pfb_pkg::IDX_ACCESS_MODE: io_rdata <= {1'h0, access_mode};
				default: io_rdata <= 8'h00;
			endcase
		end
	end

	always_comb
	begin
		logic [15:0] dbl;
		dbl = {cpu_wdata, cpu_wdata} >> rotate_logic[pfb_pkg::ROT_LSB +: 3];
		rot_data = dbl[7:0];
	end

	// per-plane write data
	generate
		for (genvar p = 0; p < pfb_pkg::NUM_PLANES; p++)
		begin : g_wr
			logic [7:0] src;
			logic [7:0] lop;
			logic [7:0] msk;
			always_comb
			begin
				case (wmode)
					2'b00: src = fill_enable[p] ? {8{fill_value[p]}} : rot_data;
					2'b10: src = {8{cpu_wdata[p]}};
					2'b11: src = {8{fill_value[p]}};
					default: src = latch[p];
				endcase
				case (pfb_pkg::pfb_func_t'(rotate_logic[pfb_pkg::FUNC_LSB +: 2]))
					pfb_pkg::pfb_func_and: lop = src & latch[p];
					pfb_pkg::pfb_func_or: lop = src | latch[p];
					pfb_pkg::pfb_func_xor: lop = src ^ latch[p];
					default: lop = src;
				endcase
				if (wmode == 2'b11)
					msk = rot_data & pixel_write_mask;
				else
					msk = pixel_write_mask;
				if (wmode == 2'b01)
					next_wdata[p*8 +: 8] = latch[p];
				else
					next_wdata[p*8 +: 8] = (lop & msk) | (latch[p] & ~msk);
			end

			logic [7:0] hit;
			assign hit = ~(mem_rdata[p*8 +: 8] ^ {8{colour_match[p]}})
				| {8{~colour_ignore_mask[p]}};
		end
	endgenerate

	assign cmp_bits = g_wr[0].hit & g_wr[1].hit & g_wr[2].hit & g_wr[3].hit;

	// plane steering
	always_comb
	begin
		if (chain_four)
			next_plane_en = plane_write_mask & (4'h1 << cpu_addr[1:0]);
		else if (access_mode[pfb_pkg::ODDEVEN_BIT])
			next_plane_en = plane_write_mask
				& (cpu_addr[0] ? 4'ha : 4'h5);
		else
			next_plane_en = plane_write_mask;
		if (chain_four)
			eff_plane = cpu_addr[1:0];
		else if (access_mode[pfb_pkg::ODDEVEN_BIT])
			eff_plane = {read_plane[1], cpu_addr[0]};
		else
			eff_plane = read_plane;
	end

	// cpu access sequencing; a read waits for the planes to answer
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= pfb_idle;
			mem_req <= '0;
			mem_addr <= '0;
			rd_plane_q <= 2'h0;
			cpu_busy <= 1'b0;
		end
		else
		begin
			mem_req.wr <= 1'b0;
			mem_req.rd <= 1'b0;
			case (state)
				pfb_idle:
				begin
					if (cpu_rd)
					begin
						mem_req.rd <= 1'b1;
						mem_addr <= cpu_addr;
						rd_plane_q <= eff_plane;
						cpu_busy <= 1'b1;
						state <= pfb_rd_wait;
					end
					else if (cpu_wr)
					begin
						mem_req.wr <= 1'b1;
						mem_req.plane_en <= next_plane_en;
						mem_req.wdata <= next_wdata;
						mem_addr <= cpu_addr;
					end
				end
				pfb_rd_wait:
				begin
					if (mem_rvalid)
					begin
						cpu_busy <= 1'b0;
						state <= pfb_idle;
					end
				end
				default: state <= pfb_idle;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int p = 0; p < pfb_pkg::NUM_PLANES; p++)
				latch[p] <= 8'h00;
		end
		else if (state == pfb_rd_wait && mem_rvalid)
		begin
			for (int p = 0; p < pfb_pkg::NUM_PLANES; p++)
				latch[p] <= mem_rdata[p*8 +: 8];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cpu_rdata <= 8'h00;
			cpu_rdone <= 1'b0;
		end
		else
		begin
			cpu_rdone <= state == pfb_rd_wait && mem_rvalid;
			if (state == pfb_rd_wait && mem_rvalid)
			begin
				if (access_mode[pfb_pkg::RMODE_BIT])
					cpu_rdata <= cmp_bits;
				else
					cpu_rdata <= mem_rdata[rd_plane_q*8 +: 8];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			latch_readback <= 8'h00;
		else
			latch_readback <= latch[read_plane];
	end

	// display serialiser; a new load restarts the eight transfers
	always_comb
	begin
		case (access_mode[pfb_pkg::SHIFT_LSB +: 2])
			2'b01:
				if (xfer[2])
					next_pixel = {shift_buf[3][7:6], shift_buf[1][7:6]};
				else
					next_pixel = {shift_buf[2][7:6], shift_buf[0][7:6]};
			2'b00:
				next_pixel = {shift_buf[3][7], shift_buf[2][7],
					shift_buf[1][7], shift_buf[0][7]};
			default:
				next_pixel = xfer[0] ? shift_buf[xfer[2:1]][3:0]
					: shift_buf[xfer[2:1]][7:4];
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int p = 0; p < pfb_pkg::NUM_PLANES; p++)
				shift_buf[p] <= 8'h00;
			xfer <= 3'h0;
			shifting <= 1'b0;
			pixel_out <= 4'h0;
			pixel_valid <= 1'b0;
		end
		else
		begin
			pixel_valid <= shifting;
			pixel_out <= shifting ? next_pixel : 4'h0;
			if (disp_load)
			begin
				for (int p = 0; p < pfb_pkg::NUM_PLANES; p++)
					shift_buf[p] <= disp_data[p*8 +: 8];
				xfer <= 3'h0;
				shifting <= 1'b1;
			end
			else if (shifting)
			begin
				xfer <= xfer + 3'h1;
				if (xfer == 3'(pfb_pkg::XFERS - 1))
					shifting <= 1'b0;
				// mode 1x indexes the buffer, the others shift it
				case (access_mode[pfb_pkg::SHIFT_LSB +: 2])
					2'b00:
						for (int p = 0; p < pfb_pkg::NUM_PLANES; p++)
							shift_buf[p] <= {shift_buf[p][6:0], 1'b0};
					// only the pair on the outputs moves; the other waits whole
					2'b01:
						if (xfer[2])
						begin
							shift_buf[1] <= {shift_buf[1][5:0], 2'b00};
							shift_buf[3] <= {shift_buf[3][5:0], 2'b00};
						end
						else
						begin
							shift_buf[0] <= {shift_buf[0][5:0], 2'b00};
							shift_buf[2] <= {shift_buf[2][5:0], 2'b00};
						end
					default: ;
				endcase
			end
		end
	end
endmodule // pfb_datapath
`default_nettype wire

// ==== logic/pfb_pkg.sv ====
// constants and carrier types for the planar frame buffer datapath
`default_nettype none
package pfb_pkg;
	localparam int NUM_PLANES = 4;
	localparam int XFERS = 8;

	// register indexes at the data port
	localparam logic [7:0] IDX_FILL_VALUE = 8'h00;
	localparam logic [7:0] IDX_FILL_ENABLE = 8'h01;
	localparam logic [7:0] IDX_COLOUR_MATCH = 8'h02;
	localparam logic [7:0] IDX_ROTATE_LOGIC = 8'h03;
	localparam logic [7:0] IDX_READ_PLANE = 8'h04;
	localparam logic [7:0] IDX_ACCESS_MODE = 8'h05;

	// values after reset
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [4:0] RST_ROTATE_LOGIC = 5'h00;
	localparam logic [1:0] RST_READ_PLANE = 2'h0;
	localparam logic [6:0] RST_ACCESS_MODE = 7'h00;

	// field positions
	localparam int ROT_LSB = 0;
	localparam int FUNC_LSB = 3;
	localparam int WMODE_LSB = 0;
	localparam int RMODE_BIT = 3;
	localparam int ODDEVEN_BIT = 4;
	localparam int SHIFT_LSB = 5;

	typedef enum logic [1:0] {
		pfb_func_pass,
		pfb_func_and,
		pfb_func_or,
		pfb_func_xor
	} pfb_func_t;

	// one request towards the four memory planes
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] plane_en;
		logic [31:0] wdata;
	} pfb_mem_req_t;

	// host register port strobe and data
	typedef struct packed {
		logic index_wr;
		logic data_wr;
		logic data_rd;
		logic [7:0] wdata;
	} pfb_io_req_t;
endpackage
`default_nettype wire

// ==== test/pfb_datapath_sva.sv ====
// port timing checks for the frame buffer datapath
`default_nettype none
module pfb_datapath_sva #(
	parameter int ADDR_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic cpu_busy,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rdone,
	input wire pfb_pkg::pfb_mem_req_t mem_req,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic disp_load,
	input wire logic pixel_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	wr_issue_a: assert property (
		cpu_wr && !cpu_rd && !cpu_busy |=> mem_req.wr && !mem_req.rd)
		else $error("write not issued");
	rd_issue_a: assert property (
		cpu_rd && !cpu_busy |=> mem_req.rd && cpu_busy)
		else $error("read not issued");
	rd_done_a: assert property (
		cpu_busy && mem_rvalid |=> cpu_rdone && !cpu_busy)
		else $error("read not completed");
	done_pulse_a: assert property (cpu_rdone |=> !cpu_rdone)
		else $error("read done too long");
	busy_block_a: assert property (
		cpu_busy |=> !mem_req.wr && !mem_req.rd)
		else $error("access while busy");
	addr_pass_a: assert property (
		mem_req.wr || mem_req.rd |-> mem_addr == $past(cpu_addr))
		else $error("address not passed");
	rdata_hold_a: assert property (!cpu_rdone |-> $stable(cpu_rdata))
		else $error("read data moved");
	pixel_run_a: assert property (disp_load |-> ##2 pixel_valid[*8])
		else $error("pixel run short");
	pixel_end_a: assert property (
		disp_load ##1 !disp_load[*8] |-> ##2 !pixel_valid)
		else $error("pixel run long");
endmodule // pfb_datapath_sva
bind pfb_datapath pfb_datapath_sva #(.ADDR_W(ADDR_W)) i_sva (
	.clock(clock), .rst(rst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
	.cpu_addr(cpu_addr), .cpu_busy(cpu_busy), .cpu_rdata(cpu_rdata),
	.cpu_rdone(cpu_rdone), .mem_req(mem_req), .mem_addr(mem_addr),
	.mem_rvalid(mem_rvalid), .disp_load(disp_load),
	.pixel_valid(pixel_valid));
`default_nettype wire

// ==== test/pfb_datapath_tb.sv ====
// self-checking bench for the planar frame buffer datapath
`default_nettype none
module pfb_datapath_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic rst = 1;
	pfb_pkg::pfb_io_req_t io_req = '0;
	pfb_pkg::pfb_mem_req_t mreq;
	logic [7:0] io_rdata, pwm = 8'hff, wd = 0, rd_data, latch_rb;
	logic [3:0] cim = 4'hf, plm = 4'hf, pix;
	logic cpu_wr = 0, cpu_rd = 0, busy, rdone, rvalid, load = 0, pvalid;
	logic chain_four = 0;
	logic [15:0] addr = 0, maddr;
	logic [31:0] rdata, ddata = 32'h96c3a55a;
	logic [7:0] rmask [7] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7f, 0};
	logic [7:0] fexp [4] = '{8'h3c, 8'h18, 8'h7e, 8'h66};
	int failures = 0;
	int comparisons = 0;
	always #5 clock = ~clock;
	pfb_datapath i_dut (.clock(clock), .rst(rst), .io_req(io_req),
		.io_rdata(io_rdata), .pixel_write_mask(pwm),
		.colour_ignore_mask(cim), .plane_write_mask(plm),
		.chain_four(chain_four), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_addr(addr), .cpu_wdata(wd), .cpu_busy(busy),
		.cpu_rdata(rd_data), .cpu_rdone(rdone),
		.latch_readback(latch_rb), .mem_req(mreq), .mem_addr(maddr),
		.mem_rvalid(rvalid), .mem_rdata(rdata), .disp_load(load),
		.disp_data(ddata), .pixel_out(pix), .pixel_valid(pvalid));
	pfb_mem_model i_mem (.clock(clock), .mem_req(mreq), .mem_addr(maddr),
		.mem_rvalid(rvalid), .mem_rdata(rdata));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(int n = 1);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// index first, then data access
	task automatic reg_acc(logic [7:0] idx, logic [7:0] val, logic rd);
		io_req = '{1'b1, 1'b0, 1'b0, idx};
		cyc();
		io_req = '{1'b0, !rd, rd, val};
		cyc();
		io_req = '0;
		cyc();
	endtask
	task automatic fb_wr(logic [15:0] a, logic [7:0] d);
		addr = a;
		wd = d;
		cpu_wr = 1;
		cyc();
		cpu_wr = 0;
		cyc(2);
	endtask
	task automatic fb_rd(logic [15:0] a);
		int n = 0;
		addr = a;
		cpu_rd = 1;
		cyc();
		cpu_rd = 0;
		while (rdone !== 1'b1 && n < 20)
		begin
			cyc();
			n++;
		end
		chk("read done", 1, rdone);
		cyc();
	endtask
	function automatic logic [3:0] px(int m, int k, logic [31:0] d);
		logic [7:0] p [4];
		int j;
		p = '{d[7:0], d[15:8], d[23:16], d[31:24]};
		j = k % 4;
		if (m == 0)
			return {p[3][7-k], p[2][7-k], p[1][7-k], p[0][7-k]};
		if (m == 1)
			return k < 4 ? {p[2][7-2*j-:2], p[0][7-2*j-:2]}
				: {p[3][7-2*j-:2], p[1][7-2*j-:2]};
		return k[0] ? p[k/2][3:0] : p[k/2][7:4];
	endfunction
	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		cyc(5000);
		failures++;
		tally_and_finish();
	end
	initial
	begin
		cyc(20);
		rst = 0;
		for (int i = 0; i < 7; i++)
		begin
			reg_acc(i[7:0], 8'hff, 0);
			reg_acc(i[7:0], 8'h00, 1);
			chk("register", rmask[i], io_rdata);
		end
		$display("test registers done");
		reg_acc(5, 0, 0);
		reg_acc(1, 0, 0);
		reg_acc(3, 0, 0);
		fb_wr(0, 8'h5a);
		chk("planes", 32'h5a5a5a5a, i_mem.mem[0]);
		fb_rd(0);
		for (int f = 0; f < 4; f++)
		begin
			reg_acc(3, f[7:0] << 3, 0);
			fb_wr(2 + f, 8'h3c);
			chk("planes", {4{fexp[f]}}, i_mem.mem[2+f]);
		end
		reg_acc(0, 8'h05, 0);
		reg_acc(1, 8'h03, 0);
		reg_acc(3, 8'h1b, 0);
		pwm = 8'hf0;
		fb_wr(1, 8'h81);
		chk("planes", 32'h6a6a5aaa, i_mem.mem[1]);
		reg_acc(5, 1, 0);
		fb_wr(8, 8'hc3);
		chk("planes", 32'h5a5a5a5a, i_mem.mem[8]);
		reg_acc(5, 2, 0);
		reg_acc(3, 0, 0);
		pwm = 8'h0f;
		fb_wr(9, 8'hf5);
		chk("planes", 32'h505f505f, i_mem.mem[9]);
		reg_acc(5, 3, 0);
		reg_acc(0, 8'h0a, 0);
		reg_acc(3, 1, 0);
		pwm = 8'hff;
		fb_wr(10, 8'h0f);
		chk("planes", 32'hdf58df58, i_mem.mem[10]);
		$display("test writes done");
		reg_acc(5, 0, 0);
		reg_acc(1, 0, 0);
		reg_acc(3, 0, 0);
		for (int p = 0; p < 4; p++)
		begin
			plm = 4'h1 << p;
			fb_wr(12, 8'h11 << p);
		end
		plm = 4'hf;
		for (int p = 0; p < 4; p++)
		begin
			reg_acc(4, p[7:0], 0);
			fb_rd(12);
			chk("read data", 8'h11 << p, rd_data);
			chk("latch", 8'h11 << p, latch_rb);
		end
		reg_acc(5, 8'h10, 0);
		reg_acc(4, 3, 0);
		fb_rd(12);
		chk("read data", 8'h44, rd_data);
		fb_wr(13, 8'h77);
		chk("planes", 32'h77007700, i_mem.mem[13] & 32'hff00ff00);
		chain_four = 1;
		fb_rd(12);
		chk("read data", 8'h11, rd_data);
		fb_wr(14, 8'h5c);
		chk("planes", 32'h005c0000, i_mem.mem[14] & 32'h00ff0000);
		chain_four = 0;
		reg_acc(5, 8'h08, 0);
		reg_acc(2, 1, 0);
		fb_rd(12);
		chk("compare", 8'h11, rd_data);
		cim = 4'h0;
		fb_rd(12);
		chk("compare", 8'hff, rd_data);
		$display("test reads done");
		for (int m = 0; m < 4; m++)
		begin
			reg_acc(5, m[7:0] << 5, 0);
			load = 1;
			cyc();
			load = 0;
			// first transfer stands one edge after the load edge
			cyc();
			for (int k = 0; k < 8; k++)
			begin
				chk("pixel", {1'b1, px(m, k, ddata)}, {pvalid, pix});
				cyc();
			end
			chk("pixel valid", 0, pvalid);
		end
		$display("test serialiser done");
		tally_and_finish();
	end
endmodule // pfb_datapath_tb
`default_nettype wire

// ==== test/pfb_mem_model.sv ====
// four memory planes answering the datapath, prompt and slow in turn
`default_nettype none
module pfb_mem_model (
	input wire logic clock,
	input wire pfb_pkg::pfb_mem_req_t mem_req,
	input wire logic [15:0] mem_addr,
	output logic mem_rvalid,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [16];
	logic [3:0] ra;
	logic [1:0] left = 2'h0;
	logic slow = 1'b0;
	always_ff @(posedge clock)
	begin
		mem_rvalid <= 1'b0;
		// released data lines keep changing so stale values never match
		mem_rdata <= ~mem_rdata;
		if (mem_req.wr)
			for (int p = 0; p < 4; p++)
				if (mem_req.plane_en[p])
					mem[mem_addr[3:0]][p*8+:8] <= mem_req.wdata[p*8+:8];
		if (mem_req.rd)
		begin
			ra <= mem_addr[3:0];
			left <= slow ? 2'h3 : 2'h1;
			slow <= ~slow;
		end
		else if (left != 2'h0)
		begin
			left <= left - 2'h1;
			if (left == 2'h1)
			begin
				mem_rvalid <= 1'b1;
				mem_rdata <= mem[ra];
			end
		end
	end
endmodule // pfb_mem_model
`default_nettype wire
